// ==== rtl/mpfs_map.svh ====
// Register map, field positions, reset values and timing figures of the
// monitor pin function select block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef MPFS_MAP_SVH
`define MPFS_MAP_SVH

// Clock rate and sample rates in samples per second.
`define MPFS_CLK_HZ        100000000
`define MPFS_SPS_8         8
`define MPFS_SPS_64        64
`define MPFS_SPS_256       256
`define MPFS_SPS_1024      1024

// Byte offsets of the registers.
`define MPFS_OFF_CTRL      12'h000
`define MPFS_OFF_STATUS    12'h004
`define MPFS_OFF_IRQ_STAT  12'h008
`define MPFS_OFF_IRQ_MASK  12'h00C

// Control register fields.
`define MPFS_CTRL_AMODE_LSB 0
`define MPFS_CTRL_AMODE_MSB 1
`define MPFS_CTRL_A_DIR     2
`define MPFS_CTRL_A_OUT     3
`define MPFS_CTRL_B_ALERT   4
`define MPFS_CTRL_B_DIR     6
`define MPFS_CTRL_B_OUT     7
`define MPFS_CTRL_RATE_LSB  8
`define MPFS_CTRL_RATE_MSB  9
`define MPFS_CTRL_RST       32'h0000_0000
`define MPFS_CTRL_WMASK     32'h0000_03DF

// Status register fields.
`define MPFS_ST_RATE_LSB    0
`define MPFS_ST_RATE_MSB    1
`define MPFS_ST_A_LVL       2
`define MPFS_ST_B_LVL       3
`define MPFS_ST_DOWN        4
`define MPFS_ST_SLOW        5

// Interrupt status and mask bits.
`define MPFS_IRQ_W          4
`define MPFS_IRQ_A_EDGE     0
`define MPFS_IRQ_B_EDGE     1
`define MPFS_IRQ_RATE       2
`define MPFS_IRQ_WAKE       3
`define MPFS_IRQ_RST        4'h0

// Synchroniser lanes and their reset levels.
`define MPFS_SYN_N          3
`define MPFS_SYN_A          0
`define MPFS_SYN_B          1
`define MPFS_SYN_SD         2
`define MPFS_SYN_RST        3'h4

`endif

// ==== rtl/mpfs_pkg.sv ====
// Types shared by the monitor pin function select design.
// Assumes nothing of its surroundings.
package mpfs_pkg;

	// Role of the first multi-purpose pin, Gray ordered.
	typedef enum logic [1:0] {
		MPFS_A_RATE  = 2'h0,
		MPFS_A_ALERT = 2'h1,
		MPFS_A_GPIO  = 2'h3
	} mpfs_amode_e;

	// Sample rate codes, Gray ordered from fast to slow.
	typedef enum logic [1:0] {
		MPFS_R1024 = 2'h0,
		MPFS_R256  = 2'h1,
		MPFS_R64   = 2'h3,
		MPFS_R8    = 2'h2
	} mpfs_rate_e;

	// Power state of the block.
	typedef enum logic [1:0] {
		MPFS_P_ACTIVE = 2'h0,
		MPFS_P_DOWN   = 2'h1,
		MPFS_P_WAKE   = 2'h3
	} mpfs_pwr_e;

endpackage : mpfs_pkg

// ==== rtl/mpfs_sync_if.sv ====
// Interface carrying raw pin levels to the synchroniser and clean levels back.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface mpfs_sync_if #(
	parameter int N = 3
);
	logic [N-1:0] raw;
	logic [N-1:0] clean;
	modport host (output raw, input clean);
	modport filt (input raw, output clean);
endinterface : mpfs_sync_if

// ==== rtl/mpfs_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels on raw and a free-running pclk.
`timescale 1ns/10ps
module mpfs_pin_sync #(
	parameter int           N   = 3,
	parameter logic [N-1:0] RST = '0
) (
	input wire logic pclk,       // System clock.
	input wire logic presetn,    // Asynchronous reset, active low.
	input wire logic ce,         // Clock enable, freezes state when low.
	mpfs_sync_if.filt sif        // Raw levels in, clean levels out.
);

	logic [N-1:0] s1_r;
	logic [N-1:0] s2_r;
	logic [N-1:0] s3_r;
	logic [N-1:0] clean_r;

	// ===================================================================
	// Per-lane chain: a level counts once stages two and three agree.
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_lane
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_r[i]    <= RST[i];
					s2_r[i]    <= RST[i];
					s3_r[i]    <= RST[i];
					clean_r[i] <= RST[i];
				end else if (ce) begin
					s1_r[i] <= sif.raw[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
					if (s2_r[i] == s3_r[i]) begin
						clean_r[i] <= s3_r[i];
					end
				end
			end
		end
	endgenerate

	assign sif.clean = clean_r;

endmodule : mpfs_pin_sync

// ==== rtl/mpfs_top.sv ====
// Pin function select of the power monitor with an APB register slave.
// Assumes open-drain pins with external pull-ups and one 100 MHz clock.
//
// Summary of operation
// R1: Rate pin high in its default role forces sampling to 8 SPS.
// R2: Rate pin low gives 1024 SPS unless software programmed another rate.
// R3: Software may turn the rate pin into the first open-drain alert output.
// R4: First pin in general-purpose mode is input by default, or open-drain out.
// R5: After reset second pin is general-purpose input; may be output or alert.
// R6: Second pin is only ever pulled low or released, in every output role.
// R7: Power-down input low stops all circuitry, the register interface too; the synchroniser and irq keep running, and APB accesses get an error.
// R8: In alert or general-purpose role the first pin never forces the rate.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "mpfs_map.svh"
module mpfs_top #(
	parameter int unsigned CNT_W       = 24,
	parameter int unsigned PERIOD_1024 = `MPFS_CLK_HZ / `MPFS_SPS_1024,
	parameter int unsigned PERIOD_256  = `MPFS_CLK_HZ / `MPFS_SPS_256,
	parameter int unsigned PERIOD_64   = `MPFS_CLK_HZ / `MPFS_SPS_64,
	parameter int unsigned PERIOD_8    = `MPFS_CLK_HZ / `MPFS_SPS_8
) (
	input  wire logic        pclk,           // System clock.
	input  wire logic        presetn,        // Asynchronous reset, active low.
	input  wire logic        ce,             // Clock enable.
	input  wire logic [11:0] paddr,          // APB byte address.
	input  wire logic        psel,           // APB select.
	input  wire logic        penable,        // APB enable.
	input  wire logic        pwrite,         // APB write direction.
	input  wire logic [31:0] pwdata,         // APB write data.
	input  wire logic [3:0]  pstrb,          // APB byte strobes.
	output logic      [31:0] prdata,         // APB read data.
	output logic             pready,         // APB ready.
	output logic             pslverr,        // APB error.
	input  wire logic        pin_a_i,        // First pin level.
	output logic             pin_a_o,        // First pin drive value.
	output logic             pin_a_oe,       // First pin pulls low when high.
	input  wire logic        pin_b_i,        // Second pin level.
	output logic             pin_b_o,        // Second pin drive value.
	output logic             pin_b_oe,       // Second pin pulls low when high.
	input  wire logic        shutdown_n,     // Power-down pin, active low.
	input  wire logic        flag_out_a_req, // First alert request.
	input  wire logic        flag_out_b_req, // Second alert request.
	output logic             sample_tick,    // One pulse per sample period.
	output logic      [1:0]  rate_sel,       // Effective rate code.
	output logic             powered_down,   // High in power-down.
	output logic             irq             // Level interrupt.
);

	// ===================================================================
	// Declarations.
	logic [31:0]             ctrl_r;
	logic [`MPFS_IRQ_W-1:0]  istat_r;
	logic [`MPFS_IRQ_W-1:0]  imask_r;
	logic [`MPFS_IRQ_W-1:0]  iev;
	logic [`MPFS_IRQ_W-1:0]  iclr;
	mpfs_pkg::mpfs_pwr_e     pwr_r;
	mpfs_pkg::mpfs_amode_e   amode;
	mpfs_pkg::mpfs_rate_e    prog_rate;
	mpfs_pkg::mpfs_rate_e    rate_nxt;
	mpfs_pkg::mpfs_rate_e    rate_r;
	logic [CNT_W-1:0]        cnt_r;
	logic [CNT_W-1:0]        per_last;
	logic                    tick_r;
	logic                    a_lvl;
	logic                    b_lvl;
	logic                    sd_lvl;
	logic                    a_prev_r;
	logic                    b_prev_r;
	logic                    active;
	logic                    slow_force;
	logic                    a_oe_nxt;
	logic                    b_oe_nxt;
	logic                    a_oe_r;
	logic                    b_oe_r;
	logic                    a_o_r;
	logic                    b_o_r;
	logic                    b_alert;
	logic                    acc;
	logic                    wr_en;
	logic                    hit;
	logic [31:0]             rd_nxt;
	logic [31:0]             bmask;
	logic [31:0]             prdata_r;
	logic                    pready_r;
	logic                    pslverr_r;
	logic                    down_r;
	logic                    irq_r;

	// ===================================================================
	// Pin synchroniser.
	mpfs_sync_if #(.N(`MPFS_SYN_N)) sif ();

	// Raw pin levels go to the filter; clean levels come back.
	assign sif.raw[`MPFS_SYN_A]  = pin_a_i;
	assign sif.raw[`MPFS_SYN_B]  = pin_b_i;
	assign sif.raw[`MPFS_SYN_SD] = shutdown_n;

	mpfs_pin_sync #(
		.N   (`MPFS_SYN_N),
		.RST (`MPFS_SYN_RST)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.sif     (sif)
	);

	// Clean levels of the three pins.
	assign a_lvl  = sif.clean[`MPFS_SYN_A];
	assign b_lvl  = sif.clean[`MPFS_SYN_B];
	assign sd_lvl = sif.clean[`MPFS_SYN_SD];

	// ===================================================================
	// Power state: low on the power-down pin parks the sampler, the pin drives and register access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_r <= mpfs_pkg::MPFS_P_ACTIVE;
		end else if (ce) begin
			case (pwr_r)
				mpfs_pkg::MPFS_P_ACTIVE: begin
					if (!sd_lvl) pwr_r <= mpfs_pkg::MPFS_P_DOWN; // R7
				end
				mpfs_pkg::MPFS_P_DOWN: begin
					if (sd_lvl) pwr_r <= mpfs_pkg::MPFS_P_WAKE;
				end
				mpfs_pkg::MPFS_P_WAKE: begin
					pwr_r <= sd_lvl ? mpfs_pkg::MPFS_P_ACTIVE
					                : mpfs_pkg::MPFS_P_DOWN;
				end
				default: begin
					pwr_r <= mpfs_pkg::MPFS_P_DOWN;
				end
			endcase
		end
	end

	// The wake state holds the sampler in reset for one more cycle.
	assign active = (pwr_r == mpfs_pkg::MPFS_P_ACTIVE);

	// ===================================================================
	// Rate selection from the pin role, the pin level and software.
	assign amode     = mpfs_pkg::mpfs_amode_e'(
	                   ctrl_r[`MPFS_CTRL_AMODE_MSB:`MPFS_CTRL_AMODE_LSB]);
	assign prog_rate = mpfs_pkg::mpfs_rate_e'(
	                   ctrl_r[`MPFS_CTRL_RATE_MSB:`MPFS_CTRL_RATE_LSB]);
	assign b_alert   = ctrl_r[`MPFS_CTRL_B_ALERT];

	// Rate role and its spare code let the pin force the slow rate.
	assign slow_force = !ctrl_r[`MPFS_CTRL_AMODE_LSB] && a_lvl;    // R8
	assign rate_nxt   = slow_force ? mpfs_pkg::MPFS_R8              // R1
	                               : prog_rate;                     // R2

	// Last count of the sample period for the effective rate.
	always_comb begin
		case (rate_r)
			mpfs_pkg::MPFS_R1024: per_last = CNT_W'(PERIOD_1024 - 1);
			mpfs_pkg::MPFS_R256:  per_last = CNT_W'(PERIOD_256 - 1);
			mpfs_pkg::MPFS_R64:   per_last = CNT_W'(PERIOD_64 - 1);
			mpfs_pkg::MPFS_R8:    per_last = CNT_W'(PERIOD_8 - 1);
			default:              per_last = CNT_W'(PERIOD_1024 - 1);
		endcase
	end

	// Effective rate register; a change restarts the period.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_r <= mpfs_pkg::MPFS_R1024;
		end else if (ce && active) begin
			rate_r <= rate_nxt;
		end
	end

	// Sample period counter and tick; halted while powered down.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else if (ce) begin
			if (!active || (rate_nxt != rate_r)) begin
				cnt_r  <= '0;                                           // R7
				tick_r <= 1'b0;
			end else if (cnt_r >= per_last) begin
				cnt_r  <= '0;
				tick_r <= 1'b1;
			end else begin
				cnt_r  <= cnt_r + 1'b1;
				tick_r <= 1'b0;
			end
		end
	end

	// ===================================================================
	// Pin drive: both pins are open drain, only ever pulled low.
	always_comb begin
		a_oe_nxt = 1'b0;
		b_oe_nxt = 1'b0;
		if (active) begin
			case (amode)
				mpfs_pkg::MPFS_A_ALERT: a_oe_nxt = flag_out_a_req;     // R3
				mpfs_pkg::MPFS_A_GPIO:  a_oe_nxt = ctrl_r[`MPFS_CTRL_A_DIR]
				                       & ~ctrl_r[`MPFS_CTRL_A_OUT];    // R4
				default:                a_oe_nxt = 1'b0;
			endcase
			if (b_alert) begin
				b_oe_nxt = flag_out_b_req;                             // R5
			end else begin
				b_oe_nxt = ctrl_r[`MPFS_CTRL_B_DIR]
				         & ~ctrl_r[`MPFS_CTRL_B_OUT];                  // R5
			end
		end
	end

	// Drive values are fixed low; the enables decide pull or release.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_oe_r <= 1'b0;
			b_oe_r <= 1'b0;
			a_o_r  <= 1'b0;
			b_o_r  <= 1'b0;
		end else if (ce) begin
			a_oe_r <= a_oe_nxt;                                        // R3
			b_oe_r <= b_oe_nxt;                                        // R6
			a_o_r  <= 1'b0;
			b_o_r  <= 1'b0;                                            // R6
		end
	end

	// ===================================================================
	// Interrupt events: input edges, rate change and wake-up.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_prev_r <= 1'b0;
			b_prev_r <= 1'b0;
		end else if (ce) begin
			a_prev_r <= a_lvl;
			b_prev_r <= b_lvl;
		end
	end

	// Edges count only on pins that are general-purpose inputs.
	assign iev[`MPFS_IRQ_A_EDGE] = active
	    && (amode == mpfs_pkg::MPFS_A_GPIO)
	    && !ctrl_r[`MPFS_CTRL_A_DIR] && (a_lvl != a_prev_r);
	assign iev[`MPFS_IRQ_B_EDGE] = active && !b_alert
	    && !ctrl_r[`MPFS_CTRL_B_DIR] && (b_lvl != b_prev_r);
	assign iev[`MPFS_IRQ_RATE]   = active && (rate_nxt != rate_r);
	assign iev[`MPFS_IRQ_WAKE]   = (pwr_r == mpfs_pkg::MPFS_P_WAKE);

	// ===================================================================
	// APB slave: one wait state, error on unmapped or powered-down access.
	assign acc   = psel && penable;
	assign wr_en = acc && pready_r && pwrite && hit && !down_r;
	assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
	                {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign iclr  = (wr_en && (paddr == `MPFS_OFF_IRQ_STAT) && pstrb[0])
	             ? pwdata[`MPFS_IRQ_W-1:0] : '0;

	// Address decode and read data.
	always_comb begin
		hit    = 1'b1;
		rd_nxt = '0;
		case (paddr)
			`MPFS_OFF_CTRL: rd_nxt = ctrl_r;
			`MPFS_OFF_STATUS: begin
				rd_nxt[`MPFS_ST_RATE_MSB:`MPFS_ST_RATE_LSB] = rate_r;
				rd_nxt[`MPFS_ST_A_LVL] = a_lvl;
				rd_nxt[`MPFS_ST_B_LVL] = b_lvl;
				rd_nxt[`MPFS_ST_DOWN]  = down_r;
				rd_nxt[`MPFS_ST_SLOW]  = slow_force;
			end
			`MPFS_OFF_IRQ_STAT: rd_nxt[`MPFS_IRQ_W-1:0] = istat_r;
			`MPFS_OFF_IRQ_MASK: rd_nxt[`MPFS_IRQ_W-1:0] = imask_r;
			default: hit = 1'b0;
		endcase
	end

	// Handshake: ready one cycle after the access phase starts.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= '0;
		end else if (ce) begin
			pready_r <= acc && !pready_r;
			if (acc && !pready_r) begin
				pslverr_r <= !hit || down_r;                           // R7
				prdata_r  <= (pwrite || down_r) ? 32'h0000_0000 : rd_nxt;
			end else begin
				pslverr_r <= 1'b0;
			end
		end
	end

	// Control register with byte strobes; reserved bits stay zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `MPFS_CTRL_RST;                                  // R5
		end else if (ce && wr_en && (paddr == `MPFS_OFF_CTRL)) begin
			ctrl_r <= ((ctrl_r & ~bmask) | (pwdata & bmask))
			        & `MPFS_CTRL_WMASK;                                // R3
		end
	end

	// Interrupt mask register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imask_r <= `MPFS_IRQ_RST;
		end else if (ce && wr_en && (paddr == `MPFS_OFF_IRQ_MASK)
		             && pstrb[0]) begin
			imask_r <= pwdata[`MPFS_IRQ_W-1:0];
		end
	end

	// Sticky status: a new event wins over a same-cycle clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_r <= `MPFS_IRQ_RST;
		end else if (ce) begin
			istat_r <= (istat_r & ~iclr) | iev;
		end
	end

	// Registered interrupt level and power-down flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r  <= 1'b0;
			down_r <= 1'b0;
		end else if (ce) begin
			irq_r  <= |(istat_r & imask_r);
			down_r <= (pwr_r == mpfs_pkg::MPFS_P_DOWN);                // R7
		end
	end

	// ===================================================================
	// Outputs, each straight from a flip-flop.
	assign prdata       = prdata_r;
	assign pready       = pready_r;
	assign pslverr      = pslverr_r;
	assign pin_a_o      = a_o_r;
	assign pin_a_oe     = a_oe_r;
	assign pin_b_o      = b_o_r;
	assign pin_b_oe     = b_oe_r;
	assign sample_tick  = tick_r;
	assign rate_sel     = rate_r;
	assign powered_down = down_r;
	assign irq          = irq_r;

endmodule : mpfs_top

// ==== verif/mpfs_host_model.sv ====
// Board side of the two multi-purpose pins: pull-ups and host switches.
// Assumes the block only ever pulls a pin low through its enables.
`timescale 1ns/10ps
module mpfs_host_model (
	input  wire logic a_oe,    // Block pulls first pin.
	input  wire logic a_o,     // Block drive value, first pin.
	input  wire logic b_oe,    // Block pulls second pin.
	input  wire logic b_o,     // Block drive value, second pin.
	input  wire logic low_a,   // Host pulls first pin low.
	input  wire logic low_b,   // Host pulls second pin low.
	output logic      pin_a_i, // Resolved first pin level.
	output logic      pin_b_i  // Resolved second pin level.
);
	// Wired-AND of the pull-up, the block's drive and the host's switch.
	assign pin_a_i = !(a_oe && !a_o) && !low_a;
	assign pin_b_i = !(b_oe && !b_o) && !low_b;
endmodule : mpfs_host_model

// ==== verif/mpfs_top_checker.sv ====
// Concurrent checks on the ports of the pin function select top.
// Assumes it is bound to mpfs_top and that writes use the CTRL word.
`timescale 1ns/10ps
module mpfs_top_checker (
	input wire logic        pclk,           // Clock.
	input wire logic        presetn,        // Reset, active low.
	input wire logic        ce,             // Clock enable.
	input wire logic [11:0] paddr,          // APB address.
	input wire logic        psel,           // APB select.
	input wire logic        penable,        // APB enable.
	input wire logic        pwrite,         // APB direction.
	input wire logic [31:0] pwdata,         // APB write data.
	input wire logic [3:0]  pstrb,          // APB strobes.
	input wire logic        pready,         // APB ready.
	input wire logic        pslverr,        // APB error.
	input wire logic        pin_a_i,        // First pin level.
	input wire logic        pin_a_o,        // First pin drive.
	input wire logic        pin_a_oe,       // First pin enable.
	input wire logic        pin_b_o,        // Second pin drive.
	input wire logic        pin_b_oe,       // Second pin enable.
	input wire logic        shutdown_n,     // Power-down pin.
	input wire logic        flag_out_a_req, // First alert request.
	input wire logic        flag_out_b_req, // Second alert request.
	input wire logic        sample_tick,    // Sample pulse.
	input wire logic [1:0]  rate_sel,       // Rate code.
	input wire logic        powered_down    // Power-down state.
);
	logic [9:0] ctl_r;
	logic [3:0] age_r;
	logic [3:0] pin_age_r;
	logic       pin_q_r;
	logic       calm;
	logic       quiet;

	// ==========
	// Shadow of the control word and settling counters
	// ==========
	// Control word as the last completed write left it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= 10'h000;
		end else if (psel && penable && pready && pwrite && !pslverr &&
				paddr == 12'h000) begin
			if (pstrb[0]) ctl_r[7:0] <= pwdata[7:0];
			if (pstrb[1]) ctl_r[9:8] <= pwdata[9:8];
		end
	end

	// Counts calm cycles so relations skip synchroniser latency.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age_r     <= 4'h0;
			pin_age_r <= 4'h0;
			pin_q_r   <= 1'b0;
		end else begin
			pin_q_r <= pin_a_i;
			if (!shutdown_n || powered_down || !ce || (psel && pwrite))
				age_r <= 4'h0;
			else if (age_r != 4'hF)
				age_r <= age_r + 4'h1;
			if (pin_a_i != pin_q_r)
				pin_age_r <= 4'h0;
			else if (pin_age_r != 4'hF)
				pin_age_r <= pin_age_r + 4'h1;
		end
	end

	assign calm  = age_r >= 4'h8;
	assign quiet = calm && pin_age_r >= 4'h8;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========
	// Assertions
	// ==========
	a_a_drain: assert property (pin_a_oe |-> !pin_a_o)
		else $error("First pin driven high.");
	a_b_drain: assert property (pin_b_oe |-> !pin_b_o)
		else $error("Second pin driven high.");
	a_down_quiet: assert property (
		powered_down |-> !pin_a_oe && !pin_b_oe && !sample_tick)
		else $error("Activity while powered down.");
	a_down_refuse: assert property (
		pready && powered_down && $past(powered_down, 2) |-> pslverr)
		else $error("Register access served in power-down.");
	a_rate_slow: assert property (
		quiet && !ctl_r[0] && pin_a_i |-> rate_sel == 2'h2)
		else $error("High rate pin did not force the slow rate.");
	a_rate_prog: assert property (
		quiet && (ctl_r[0] || !pin_a_i) |-> rate_sel == ctl_r[9:8])
		else $error("Rate differs from the programmed code.");
	a_alert_a: assert property (
		calm && ctl_r[1:0] == 2'h1 |-> pin_a_oe == $past(flag_out_a_req))
		else $error("First alert does not follow its request.");
	a_a_input: assert property (
		calm && ctl_r[1:0] == 2'h3 && !ctl_r[2] |-> !pin_a_oe)
		else $error("First pin driven as an input.");
	a_b_input: assert property (
		calm && !ctl_r[4] && !ctl_r[6] |-> !pin_b_oe)
		else $error("Second pin driven as an input.");
	a_b_alert: assert property (
		calm && ctl_r[4] |-> pin_b_oe == $past(flag_out_b_req))
		else $error("Second alert does not follow its request.");
endmodule : mpfs_top_checker

bind mpfs_top mpfs_top_checker u_mpfs_top_checker (.pclk(pclk),
	.presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .pslverr(pslverr), .pin_a_i(pin_a_i),
	.pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o),
	.pin_b_oe(pin_b_oe), .shutdown_n(shutdown_n),
	.flag_out_a_req(flag_out_a_req), .flag_out_b_req(flag_out_b_req),
	.sample_tick(sample_tick), .rate_sel(rate_sel),
	.powered_down(powered_down));

// ==== verif/test_monitor_pin_function_select.sv ====
// Self-checking bench of the pin function select block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module test_monitor_pin_function_select;
	logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        shutdown_n = 1'b1, fa = 1'b0, fb = 1'b0;
	logic        low_a = 1'b1, low_b = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, d;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, pslverr, pin_a_i, pin_a_o, pin_a_oe;
	logic        pin_b_i, pin_b_o, pin_b_oe, sample_tick, powered_down, irq;
	logic [1:0]  rate_sel;
	logic [33:0] exq[$];
	logic [33:0] e;
	int          error_cnt = 0, n_compared = 0, cyc = 0, n, k;
	int          seed = 32'h5235;

	// ==========
	// Clock, block and board
	// ==========
	always #5 pclk = ~pclk;

	mpfs_top #(.PERIOD_1024(16), .PERIOD_256(32), .PERIOD_64(64),
		.PERIOD_8(128)) u_mpfs_top (.pclk(pclk), .presetn(presetn),
		.ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_a_i(pin_a_i),
		.pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_i(pin_b_i),
		.pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe), .shutdown_n(shutdown_n),
		.flag_out_a_req(fa), .flag_out_b_req(fb),
		.sample_tick(sample_tick), .rate_sel(rate_sel),
		.powered_down(powered_down), .irq(irq));

	mpfs_host_model u_mpfs_host_model (.a_oe(pin_a_oe), .a_o(pin_a_o),
		.b_oe(pin_b_oe), .b_o(pin_b_o), .low_a(low_a), .low_b(low_b),
		.pin_a_i(pin_a_i), .pin_b_i(pin_b_i));

	// ==========
	// Tasks
	// ==========
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk

	// One APB transfer; the expected answer is queued for the monitor.
	task automatic apb(input logic [11:0] a, input logic w,
			input logic [31:0] wd, input logic [31:0] x, input logic er);
		exq.push_back({!w, er, x});
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Waits for the answer; only the bench timeout ends a hang.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Cycles between two sample ticks.
	task automatic gap(output int g);
		int t;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (sample_tick !== 1'b1 && t < 300);
		g = 0;
		do begin
			@(posedge pclk);
			g++;
		end while (sample_tick !== 1'b1 && g < 300);
	endtask : gap

	function automatic int per(input logic [1:0] c);
		case (c)
			2'h0: return 16;
			2'h1: return 32;
			2'h3: return 64;
			default: return 128;
		endcase
	endfunction : per

	task test_done;
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// Takes the oldest expected note whenever the slave answers.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			e = exq.pop_front();
			chk({31'h0, pslverr}, {31'h0, e[32]});
			if (e[33]) chk(prdata, e[31:0]);
		end
	end

	// Cuts a hung run short.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	// ==========
	// Main sequence
	// ==========
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
		chk({30'h0, rate_sel}, 32'h0);
		chk({30'h0, pin_a_oe, pin_b_oe}, 32'h0);
		apb(12'h000, 1'b0, 32'h0, 32'h0, 1'b0);
		apb(12'h010, 1'b0, 32'h0, 32'h0, 1'b1);
		for (k = 0; k < 4; k++) begin
			d = ($random(seed) & 32'hFFFF_FC00) | (32'(k) << 8);
			apb(12'h000, 1'b1, d, 32'h0, 1'b0);
			apb(12'h000, 1'b0, 32'h0, 32'(k) << 8, 1'b0);
			repeat (8) @(posedge pclk);
			chk({30'h0, rate_sel}, 32'(k));
			gap(n);
			chk(32'(n), 32'(per(2'(k))));
		end
		apb(12'h000, 1'b1, 32'h0, 32'h0, 1'b0);
		low_a <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({30'h0, rate_sel}, 32'h2);
		gap(n);
		chk(32'(n), 32'd128);
		apb(12'h000, 1'b1, 32'h3, 32'h0, 1'b0);
		repeat (8) @(posedge pclk);
		chk({29'h0, rate_sel, pin_a_oe}, 32'h0);
		apb(12'h000, 1'b1, 32'h7, 32'h0, 1'b0);
		repeat (4) @(posedge pclk);
		chk({30'h0, pin_a_oe, pin_a_i}, 32'h2);
		apb(12'h000, 1'b1, 32'hF, 32'h0, 1'b0);
		repeat (4) @(posedge pclk);
		chk({31'h0, pin_a_oe}, 32'h0);
		apb(12'h000, 1'b1, 32'h11, 32'h0, 1'b0);
		fa <= 1'b1;
		fb <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({28'h0, pin_a_oe, pin_a_o, pin_b_oe, pin_b_o}, 32'hA);
		fb <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({31'h0, pin_b_oe}, 32'h0);
		apb(12'h000, 1'b1, 32'h41, 32'h0, 1'b0);
		repeat (4) @(posedge pclk);
		chk({30'h0, pin_a_oe, pin_b_oe}, 32'h3);
		apb(12'h00C, 1'b1, 32'h8, 32'h0, 1'b0);
		apb(12'h008, 1'b1, 32'hF, 32'h0, 1'b0);
		shutdown_n <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({29'h0, powered_down, pin_a_oe, pin_b_oe}, 32'h4);
		apb(12'h000, 1'b0, 32'h0, 32'h0, 1'b1);
		shutdown_n <= 1'b1;
		repeat (10) @(posedge pclk);
		chk({30'h0, powered_down, irq}, 32'h1);
		apb(12'h008, 1'b0, 32'h0, 32'h8, 1'b0);
		apb(12'h008, 1'b1, 32'h8, 32'h0, 1'b0);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		// Clock enable low freezes the alert drive against its request.
		ce <= 1'b0;
		fa <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({31'h0, pin_a_oe}, 32'h1);
		ce <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({31'h0, pin_a_oe}, 32'h0);
		chk(32'(exq.size()), 32'h0);
		test_done();
	end
endmodule : test_monitor_pin_function_select
